/* File: hdl/dma_bus_cycle_request_sequencer.sv */
// bus-cycle sequencing and request acceptance for one dma channel
`timescale 1ns/1ns
`include "dma_seq_defs.svh"
module dma_bus_cycle_request_sequencer #(
  parameter int CNT_W = 16,
  parameter int BLK_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ctrlWrite,
  input wire logic ctrlChannelEnable,
  input wire logic ctrlMasterEnable,
  input wire logic [CNT_W-1:0] transferCount,
  input wire logic [BLK_W-1:0] blockSize,
  input wire logic fullAddressMode,
  input wire logic singleAddressMode,
  input wire logic burstMode,
  input wire logic blockMode,
  input wire logic repeatMode,
  input wire logic endStrobeEnable,
  input wire logic request_sense_select,
  input wire logic edgeActivation,
  input wire logic write_buffer_enable,
  input wire logic destInternal,
  input wire logic nmiRequest,
  input wire logic higherPriorityRequest,
  input wire logic busGrant,
  input wire logic external_request_n,
  input wire logic rdValid,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic wrReady,
  input wire logic singleDone,
  output logic busRequest,
  output logic readCycle,
  output logic writeCycle,
  output logic singleCycle,
  output logic deadCycle,
  output logic transfer_end_strobe_n,
  output logic channelEnableStatus,
  output logic masterEnableStatus,
  output logic requestPending,
  output logic wrValid,
  output logic [DATA_W-1:0] wrData
);
  import dma_seq_pkg::*;

  seq_state_e st_r;
  seq_state_e stNxt;
  logic reqMeta_r;
  logic reqSync_r;
  logic chanEn_r;
  logic masterEn_r;
  logic sampleOn_r;
  logic accept_r;
  logic highSeen_r;
  logic pending_r;
  logic enteredWr_r;
  logic strobe_n_r;
  logic busReq_r;
  logic readCyc_r;
  logic writeCyc_r;
  logic singleCyc_r;
  logic deadCyc_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] reload_r;
  logic [BLK_W-1:0] blkCnt_r;
  logic enabled;
  logic reqActive;
  logic activation;
  logic pop;
  logic xferDone;
  logic blkLast;
  logic lastXfer;
  logic resume;
  logic bufInReady;
  logic bufOutValid;

  // ******************************
  // two-stage pin synchroniser
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reqMeta_r <= `PIN_IDLE;
      reqSync_r <= `PIN_IDLE;
    end else begin
      reqMeta_r <= external_request_n;
      reqSync_r <= reqMeta_r;
    end
  end

  // ******************************
  // enables and transfer gating
  // ******************************
  // both enables in full mode
  assign enabled = chanEn_r && (masterEn_r || !fullAddressMode);
  assign reqActive = request_sense_select ? pending_r : enabled;
  assign activation = (st_r == ST_ARB) && busGrant;
  assign pop = (st_r == ST_WRITE) && bufOutValid && wrReady;
  assign xferDone = pop || ((st_r == ST_SINGLE) && singleDone);
  assign blkLast = blockMode && (blkCnt_r == BLK_W'(`SEQ_ONE));
  assign lastXfer = (count_r == CNT_W'(`SEQ_ONE)) &&
                    (!blockMode || blkLast);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chanEn_r <= 1'b0;
    end else if (xferDone && lastXfer && !repeatMode) begin
      chanEn_r <= 1'b0;
    end else if (ctrlWrite) begin
      chanEn_r <= ctrlChannelEnable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      masterEn_r <= 1'b0;
    end else if (nmiRequest && fullAddressMode && burstMode && chanEn_r) begin
      masterEn_r <= 1'b0;
    end else if (ctrlWrite) begin
      masterEn_r <= ctrlMasterEnable;
    end
  end

  // ******************************
  // transfer and block counters
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= CNT_W'(`SEQ_ZERO);
      reload_r <= CNT_W'(`SEQ_ZERO);
      blkCnt_r <= BLK_W'(`SEQ_ZERO);
    end else if (ctrlWrite && ctrlChannelEnable) begin
      count_r <= transferCount;
      reload_r <= transferCount;
      blkCnt_r <= blockSize;
    end else if (xferDone) begin
      if (blockMode && !blkLast) begin
        blkCnt_r <= blkCnt_r - BLK_W'(`SEQ_ONE);
      end else begin
        blkCnt_r <= blockSize;
        count_r <= lastXfer ? reload_r : count_r - CNT_W'(`SEQ_ONE);
      end
    end
  end

  // ******************************
  // request acceptance
  // ******************************
  // buffered write ends one state after start
  // block mode without single addressing resumes after dead cycle
  always_comb begin
    if (blockMode && !singleAddressMode) begin
      resume = (st_r == ST_DEAD);
    end else if (write_buffer_enable) begin
      resume = enteredWr_r;
    end else begin
      resume = xferDone;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enteredWr_r <= 1'b0;
    end else begin
      enteredWr_r <= (st_r == ST_ARB || st_r == ST_READ) &&
                     (stNxt == ST_WRITE || stNxt == ST_SINGLE);
    end
  end

  // sampling from the edge after enabling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sampleOn_r <= 1'b0;
    end else if (ctrlWrite) begin
      sampleOn_r <= ctrlChannelEnable;
    end else begin
      sampleOn_r <= sampleOn_r && chanEn_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accept_r <= 1'b0;
    end else if (ctrlWrite) begin
      accept_r <= ctrlChannelEnable;
    end else if (activation) begin
      accept_r <= 1'b0;
    end else if (resume) begin
      accept_r <= 1'b1;
    end
  end

  // edge mode waits for a high sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      highSeen_r <= 1'b0;
    end else if (ctrlWrite || activation) begin
      highSeen_r <= 1'b0;
    end else if (sampleOn_r && reqSync_r) begin
      highSeen_r <= 1'b1;
    end
  end

  // latch low level, clear on activation
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (activation || !sampleOn_r) begin
      pending_r <= 1'b0;
    end else if (accept_r && !reqSync_r &&
                 (!edgeActivation || highSeen_r)) begin
      pending_r <= 1'b1;
    end
  end

  // ******************************
  // bus cycle sequencer
  // ******************************
  always_comb begin
    stNxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (enabled && reqActive && !higherPriorityRequest) begin
          stNxt = ST_ARB;
        end
      end
      ST_ARB: begin
        if (busGrant) begin
          stNxt = singleAddressMode ? ST_SINGLE : ST_READ;
        end
      end
      ST_READ: begin
        if (rdValid) begin
          stNxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (pop) begin
          // final transfer runs to its end
          if (lastXfer || blkLast) begin
            stNxt = ST_DEAD;
          end else if (blockMode) begin
            stNxt = ST_READ;
          // dropped enable ends the burst here
          end else if (burstMode && fullAddressMode && enabled) begin
            stNxt = ST_READ;
          end else begin
            stNxt = ST_IDLE;
          end
        end
      end
      ST_SINGLE: begin
        if (singleDone) begin
          stNxt = lastXfer ? ST_DEAD : ST_IDLE;
        end
      end
      ST_DEAD: begin
        stNxt = ST_IDLE;
      end
      default: begin
        stNxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= stNxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busReq_r <= 1'b0;
    end else begin
      busReq_r <= (stNxt != ST_IDLE);
    end
  end

  // cycle type outputs, registered alongside the state
  always_ff @(posedge sys_clk) begin
    readCyc_r <= !rst && (stNxt == ST_READ);
    writeCyc_r <= !rst && (stNxt == ST_WRITE);
    singleCyc_r <= !rst && (stNxt == ST_SINGLE);
    deadCyc_r <= !rst && (stNxt == ST_DEAD);
  end

  // ******************************
  // transfer end strobe
  // ******************************
  // low in the cycle after the last transfer, repeat mode only
  // hidden when internal cycle overlaps buffered write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_n_r <= `STROBE_IDLE;
    end else begin
      strobe_n_r <= !(repeatMode && endStrobeEnable && xferDone &&
                      lastXfer && !(write_buffer_enable && destInternal));
    end
  end

  // ******************************
  // data buffer
  // ******************************
  two_entry_buffer #(
    .WIDTH(DATA_W)
  ) dataBuf (
    .sys_clk(sys_clk),
    .rst(rst),
    .inValid((st_r == ST_READ) && rdValid && bufInReady),
    .inReady(bufInReady),
    .inData(rdData),
    .outValid(bufOutValid),
    .outReady((st_r == ST_WRITE) && wrReady),
    .outData(wrData)
  );

  assign wrValid = bufOutValid;
  assign busRequest = busReq_r;
  assign readCycle = readCyc_r;
  assign writeCycle = writeCyc_r;
  assign singleCycle = singleCyc_r;
  assign deadCycle = deadCyc_r;
  assign transfer_end_strobe_n = strobe_n_r;
  assign channelEnableStatus = chanEn_r;
  assign masterEnableStatus = masterEn_r;
  assign requestPending = pending_r;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence finalWrite;
    (st_r == ST_WRITE) && pop && lastXfer;
  endsequence

  chk_dead_after_end: assert property (finalWrite |=> deadCycle)
    else $error("no dead state after final write");
  chk_dead_one_state: assert property (deadCycle |=> !deadCycle)
    else $error("dead state longer than one");
  chk_steal_release: assert property (
    (pop && !burstMode && !blockMode && !lastXfer) |=> st_r == ST_IDLE)
    else $error("bus kept after single transfer");
  chk_burst_hold: assert property (
    (pop && burstMode && fullAddressMode && enabled && !lastXfer &&
     !blockMode) |=> readCycle)
    else $error("burst released bus early");
  chk_nmi_clear: assert property (
    (nmiRequest && fullAddressMode && burstMode && chanEn_r)
    |=> !masterEn_r)
    else $error("nmi left master enable set");
  chk_pend_clear: assert property (activation |=> !pending_r)
    else $error("request not cleared on activation");
  chk_sample_start: assert property (
    (ctrlWrite && ctrlChannelEnable) |=> sampleOn_r && accept_r)
    else $error("sampling not started after enable");
  chk_strobe_cause: assert property (
    $fell(strobe_n_r) |-> $past(repeatMode && endStrobeEnable && lastXfer))
    else $error("strobe low without transfer end");
  chk_block_nmi: assert property (
    (pop && blockMode && !blkLast && !lastXfer) |=> readCycle)
    else $error("block interrupted mid-way");
endmodule

/* File: hdl/dma_seq_defs.svh */
// constants for the dma bus-cycle request sequencer
`ifndef DMA_SEQ_DEFS_SVH
`define DMA_SEQ_DEFS_SVH
`define SEQ_ONE 32'h0000_0001
`define SEQ_ZERO 32'h0000_0000
`define STROBE_IDLE 1'b1
`define PIN_IDLE 1'b1
`endif

/* File: hdl/dma_seq_pkg.sv */
// types for the dma bus-cycle request sequencer
package dma_seq_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ARB = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_SINGLE = 6'h10,
    ST_DEAD = 6'h20
  } seq_state_e;
endpackage

/* File: hdl/two_entry_buffer.sv */
// two-entry data buffer with valid/ready on both sides
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] head_r;
  logic [WIDTH-1:0] tail_r;
  logic headV_r;
  logic tailV_r;
  logic push;
  logic pop;

  assign inReady = !tailV_r;
  assign outValid = headV_r;
  assign outData = head_r;
  assign push = inValid && !tailV_r;
  assign pop = headV_r && outReady;

  // ******************************
  // entry occupancy
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      headV_r <= 1'b0;
      tailV_r <= 1'b0;
    end else begin
      headV_r <= (headV_r && !pop) || tailV_r || push;
      tailV_r <= (headV_r && !pop && push) || (tailV_r && !pop) ||
                 (tailV_r && pop && push);
    end
  end

  // ******************************
  // entry data
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (!headV_r || pop) begin
      head_r <= tailV_r ? tail_r : inData;
    end
    if (push && (tailV_r || (headV_r && !pop))) begin
      tail_r <= inData;
    end
  end
endmodule

/* File: verif/bus_partner.sv */
// bus-side responder model for the dma sequencer
`timescale 1ns/1ns
module bus_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic busRequest,
  input wire logic readCycle,
  input wire logic writeCycle,
  input wire logic singleCycle,
  output logic busGrant,
  output logic rdValid,
  output logic [15:0] rdData,
  output logic wrReady,
  output logic singleDone
);
  // ****************
  // slow responses
  // ****************
  always_ff @(posedge sys_clk) begin
    busGrant <= busRequest && !rst;
    rdValid <= readCycle && !rdValid && !rst;
    wrReady <= writeCycle && !wrReady && !stall && !rst;
    singleDone <= singleCycle && !singleDone && !rst;
    // data moves every cycle, so a stale word is never reused
    rdData <= rst ? 16'h5a3c : rdData + 16'h0001;
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the dma sequencer
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 1'b0, rst = 1'b1, ctrlWrite = 1'b0, stall = 1'b0;
  logic ctrlChannelEnable = 1'b0, ctrlMasterEnable = 1'b0;
  logic fullAddressMode = 1'b0, singleAddressMode = 1'b0;
  logic burstMode = 1'b0, blockMode = 1'b0, repeatMode = 1'b0;
  logic endStrobeEnable = 1'b0, request_sense_select = 1'b0;
  logic edgeActivation = 1'b0, write_buffer_enable = 1'b0;
  logic destInternal = 1'b0, nmiRequest = 1'b0;
  logic higherPriorityRequest = 1'b0, external_request_n = 1'b1;
  logic [15:0] transferCount = 16'h0000;
  logic [7:0] blockSize = 8'h00;
  logic [15:0] rdData, wrData;
  logic busGrant, rdValid, wrReady, singleDone, busRequest, readCycle;
  logic writeCycle, singleCycle, deadCycle, transfer_end_strobe_n;
  logic channelEnableStatus, masterEnableStatus, requestPending, wrValid;
  logic prevBr = 1'b0;
  logic [15:0] q[$];
  int err_count = 0, cmp_count = 0;
  int writes, singles, deads, strobes, rels, w;

  dma_bus_cycle_request_sequencer dut (.sys_clk, .rst, .ctrlWrite,
    .ctrlChannelEnable, .ctrlMasterEnable, .transferCount, .blockSize,
    .fullAddressMode, .singleAddressMode, .burstMode, .blockMode,
    .repeatMode, .endStrobeEnable, .request_sense_select, .edgeActivation,
    .write_buffer_enable, .destInternal, .nmiRequest,
    .higherPriorityRequest, .busGrant, .external_request_n, .rdValid,
    .rdData, .wrReady, .singleDone, .busRequest, .readCycle, .writeCycle,
    .singleCycle, .deadCycle, .transfer_end_strobe_n, .channelEnableStatus,
    .masterEnableStatus, .requestPending, .wrValid, .wrData);
  bus_partner bus (.sys_clk, .rst, .stall, .busRequest, .readCycle,
    .writeCycle, .singleCycle, .busGrant, .rdValid, .rdData, .wrReady,
    .singleDone);

  always #2 sys_clk = ~sys_clk;

  // ****************
  // tasks
  // ****************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task cfg(input logic [8:0] m, input logic [15:0] c, input logic [7:0] b,
           input logic me);
    @(posedge sys_clk);
    {fullAddressMode, singleAddressMode, burstMode, blockMode, repeatMode,
     endStrobeEnable, request_sense_select, edgeActivation,
     write_buffer_enable} <= m;
    transferCount <= c;
    blockSize <= b;
    ctrlChannelEnable <= 1'b1;
    ctrlMasterEnable <= me;
    ctrlWrite <= 1'b1;
    {writes, singles, deads, strobes, rels} = '0;
    q.delete();
    @(posedge sys_clk) ctrlWrite <= 1'b0;
  endtask
  task off;
    @(posedge sys_clk);
    ctrlChannelEnable <= 1'b0;
    ctrlMasterEnable <= 1'b0;
    ctrlWrite <= 1'b1;
    @(posedge sys_clk) ctrlWrite <= 1'b0;
  endtask
  task fin(input int n);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (i < n && (busRequest !== 1'b0 ||
           (channelEnableStatus && masterEnableStatus))) begin
      @(negedge sys_clk);
      i++;
    end
    @(negedge sys_clk);
    cmp(32'(i < n), 1);
  endtask
  task nmi;
    @(posedge sys_clk) nmiRequest <= 1'b1;
    @(posedge sys_clk) nmiRequest <= 1'b0;
  endtask
  task rep(input logic wb, input logic di);
    int i;
    @(posedge sys_clk) destInternal <= di;
    cfg(9'h158 | {8'h00, wb}, 16'h0003, 8'h01, 1'b1);
    for (i = 0; i < 60 && transfer_end_strobe_n; i++) @(negedge sys_clk);
    if (wb && di) begin
      cmp(strobes, 0);
      cmp(transfer_end_strobe_n, 1);
    end else begin
      cmp(transfer_end_strobe_n, 0);
      cmp(writes, 3);
    end
    off;
    fin(100);
  endtask

  // ****************
  // monitor
  // ****************
  always @(negedge sys_clk) begin
    if (!rst) begin
      if (writeCycle && wrValid && wrReady) begin
        writes++;
        if (q.size() == 0) cmp(1, 0);
        else cmp(wrData, q.pop_front());
      end
      if (readCycle && rdValid) q.push_back(rdData);
      singles += int'(singleCycle && singleDone);
      deads += int'(deadCycle);
      strobes += int'(!transfer_end_strobe_n);
      rels += int'(prevBr && !busRequest);
      prevBr <= busRequest;
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    cmp(transfer_end_strobe_n, 1);
    cfg(9'h100, 16'h0003, 8'h01, 1'b0);
    cyc(20);
    cmp(writes, 0);
    off;
    cfg(9'h100, 16'h0003, 8'h01, 1'b1);
    fin(200);
    cmp(rels, 3);
    cmp(channelEnableStatus, 0);
    cmp(deads, 1);
    cfg(9'h140, 16'h0004, 8'h01, 1'b1);
    wait (busRequest === 1'b1);
    @(posedge sys_clk) higherPriorityRequest <= 1'b1;
    fin(200);
    @(posedge sys_clk) higherPriorityRequest <= 1'b0;
    cmp(writes, 4);
    cmp(rels, 1);
    cfg(9'h140, 16'h0008, 8'h01, 1'b1);
    wait (writes == 2);
    w = writes;
    nmi;
    fin(200);
    cmp(masterEnableStatus, 0);
    cmp(32'(writes <= w + 1), 1);
    off;
    cfg(9'h140, 16'h0002, 8'h01, 1'b1);
    wait (writes == 1);
    nmi;
    fin(200);
    cmp(writes, 2);
    off;
    @(posedge sys_clk) external_request_n <= 1'b0;
    cyc(5);
    cmp(requestPending, 0);
    @(posedge sys_clk) stall <= 1'b1;
    cfg(9'h124, 16'h0002, 8'h03, 1'b1);
    cyc(3);
    nmi;
    cyc(6);
    stall <= 1'b0;
    fin(300);
    cmp(writes, 6);
    cmp(rels, 2);
    cmp(deads, 2);
    cmp(masterEnableStatus, 1);
    cfg(9'h084, 16'h0002, 8'h01, 1'b1);
    fin(200);
    cmp(singles, 2);
    @(posedge sys_clk) external_request_n <= 1'b1;
    cfg(9'h106, 16'h0003, 8'h01, 1'b1);
    external_request_n <= 1'b0;
    cyc(30);
    cmp(writes, 1);
    // requester returns high between requests
    // pin high gap
    external_request_n <= 1'b1;
    cyc(3);
    external_request_n <= 1'b0;
    cyc(30);
    cmp(writes, 2);
    external_request_n <= 1'b1;
    off;
    rep(1'b0, 1'b0);
    rep(1'b1, 1'b1);
    rep(1'b1, 1'b0);
    complete_run;
  end

  initial begin
    #200000;
    err_count++;
    complete_run;
  end
endmodule
